// >>> apt_pkg.sv
/*
 Constants shared by the converter control block: control word layout, timing counts
 and sequencer encodings.
 Assumes a 100 MHz system clock and a 16-bit serial frame.
*/
package apt_pkg;
   ////////////////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_MHZ = 100;
   localparam int PD_LONG_NS = 100;
   localparam int PD_LONG_CYC = (PD_LONG_NS * CLK_MHZ + 999) / 1000;
   localparam int PD_MIN_NS = 20;
   localparam int PD_MIN_CYC_RAW = (PD_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int PD_MIN_CYC = (PD_MIN_CYC_RAW < 1) ? 1 : PD_MIN_CYC_RAW;
   localparam int WAKE_US = 100;
   localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
   localparam int TEMP_TOTAL_US = 100;
   localparam int TEMP_TOTAL_CYC = TEMP_TOTAL_US * CLK_MHZ;
   localparam int TEMP_CONV_CYC = 16;
   localparam int RST_HOLD_CYC = 2;
   localparam int TIMER_W = 14;
   localparam int PD_CNT_W = 4;
   ////////////////////////////////////////////////////////////////////////////////////////
   // Serial frame and control word
   localparam int FRAME_BITS = 16;
   localparam int CODE_W = 12;
   localparam int ID_W = 4;
   localparam int NUM_CH = 8;
   localparam int CTRL_WRITE_BIT = 15;
   localparam int CTRL_REPEAT_BIT = 14;
   localparam int CTRL_CH0_BIT = 13;
   localparam int CTRL_TEMP_SEL_BIT = 5;
   localparam int CTRL_EXT_REF_BIT = 2;
   localparam int CTRL_TEMP_AVG_BIT = 1;
   localparam int CTRL_PWR_DN_BIT = 0;
   localparam logic [15:0] CTRL_RST_VAL = 16'h0000;
   localparam logic [15:0] TX_RST_VAL = 16'h0000;
   localparam logic [3:0] TEMP_ID = 4'h8;
   localparam logic [4:0] LAST_EDGE = 5'h0f;
   localparam logic [4:0] FRAME_DONE = 5'h10;
endpackage : apt_pkg

// >>> apt_sync.sv
/*
 Two flip-flop level synchroniser.
 Assumes the input is a level that is stable for at least two destination clock edges.
*/
`timescale 1ns/1ns
module apt_sync
#(
   parameter logic RST_VAL = 1'b0
)
(
   input wire logic i_clk,   // Destination clock
   input wire logic i_rst_n, // Synchronous reset, active low
   input wire logic i_d,     // Asynchronous level
   output logic o_q          // Synchronised level
);
   logic meta_r;
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         meta_r <= RST_VAL;
         o_q <= RST_VAL;
      end
      else
      begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule : apt_sync

// >>> apt_ctrl.sv
/*
 Digital control of an eight-channel converter with a temperature channel: power-down
 pin handling, serial link with control word, channel sequencer, one-frame latency
 and temperature integration and conversion with running average.
 Assumes the analog front end presents the selected channel code on I_CH_CODE in the
 serial clock domain and the temperature code on I_TEMP_CODE in the system domain.
*/
`timescale 1ns/1ns
module apt_ctrl
   import apt_pkg::*;
#(
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter int TEMP_CYCLES = TEMP_TOTAL_CYC
)
(
   input wire logic I_CLK,                // System clock, 100 MHz
   input wire logic I_RST_N,              // Power-on reset, synchronous, active low
   input wire logic I_PD_N,               // Power-down pin, asynchronous, active low
   input wire logic I_SCLK,               // Serial clock, link domain
   input wire logic I_CS_N,               // Chip select, active low
   input wire logic I_DIN,                // Serial write data
   input wire logic [CODE_W-1:0] I_CH_CODE,   // Analog code of selected channel
   input wire logic [CODE_W-1:0] I_TEMP_CODE, // Temperature code, twos complement
   output logic O_DOUT,                   // Serial read data
   output logic O_DOUT_OE,                // Serial read data drive enable
   output logic [ID_W-1:0] O_MUX_SEL,     // Channel under conversion
   output logic O_EXT_REF,                // External reference selected
   output logic O_PARTIAL_PD,             // Partial power-down active
   output logic O_FULL_PD,                // Full power-down active
   output logic O_READY,                  // Wake delay elapsed
   output logic O_TEMP_BUSY               // Temperature conversion pending
);
   typedef enum logic [2:0]
   {
      PW_ACTIVE = 3'b001,
      PW_LOW = 3'b010,
      PW_OFF = 3'b100
   } apt_pw_e;

   typedef enum logic [2:0]
   {
      TS_IDLE = 3'b001,
      TS_INTEG = 3'b010,
      TS_CONV = 3'b100
   } apt_ts_e;

   localparam logic [TIMER_W-1:0] WAKE_LAST = TIMER_W'(WAKE_CYCLES - 1);
   localparam logic [TIMER_W-1:0] INTEG_LAST = TIMER_W'(TEMP_CYCLES - TEMP_CONV_CYC - 1);
   localparam logic [TIMER_W-1:0] CONV_LAST = TIMER_W'(TEMP_CONV_CYC - 1);
   localparam logic [PD_CNT_W-1:0] PD_LONG = PD_CNT_W'(PD_LONG_CYC);
   localparam logic [PD_CNT_W-1:0] PD_MIN = PD_CNT_W'(PD_MIN_CYC);
   localparam logic [1:0] HOLD_LAST = 2'(RST_HOLD_CYC - 1);

   // Pending set from a control word: bit i is channel i, top bit the temperature
   function automatic logic [NUM_CH:0] seq_mask(input logic [15:0] w);
      logic [NUM_CH:0] m;
      m = '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         m[i] = w[CTRL_CH0_BIT - i];
      end
      m[NUM_CH] = w[CTRL_TEMP_SEL_BIT];
      return m;
   endfunction : seq_mask

   // Lowest pending entry; analog channels come before the temperature
   function automatic logic [ID_W-1:0] lowest(input logic [NUM_CH:0] m);
      logic [ID_W-1:0] idx;
      idx = '0;
      for (int i = NUM_CH; i >= 0; i--)
      begin
         if (m[i])
         begin
            idx = ID_W'(i);
         end
      end
      return idx;
   endfunction : lowest

   // Moving average: seven eighths of previous plus one eighth of current
   function automatic logic [CODE_W-1:0] avg_step(input logic [CODE_W-1:0] prev,
                                                  input logic [CODE_W-1:0] cur);
      logic signed [CODE_W+3:0] sum;
      sum = 16'(signed'(prev)) * 16'sd7 + 16'(signed'(cur));
      return CODE_W'(sum >>> 3);
   endfunction : avg_step

   ////////////////////////////////////////////////////////////////////////////////////////
   // System domain: power-down pin, internal reset, wake delay
   logic pd_s;
   logic pdb_s;
   logic pdb_q_r;
   logic avg_s;
   logic avg_q_r;
   logic tsel_s;
   logic tstart_s;
   logic tstart_q_r;
   apt_pw_e pw_r;
   logic [PD_CNT_W-1:0] low_cnt_r;
   logic full_pd_r;
   logic link_rst_r;
   logic [1:0] hold_r;
   logic [TIMER_W-1:0] wake_cnt_r;
   logic ready_r;
   logic pulse_rst;
   logic core_rst;

   apt_sync #(.RST_VAL(1'b1)) u_pd_sync (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_d(I_PD_N),
      .o_q(pd_s));

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         pw_r <= PW_ACTIVE;
         low_cnt_r <= '0;
      end
      else
      begin
         case (pw_r)
            PW_ACTIVE:
            begin
               low_cnt_r <= PD_CNT_W'(1);
               if (!pd_s)
               begin
                  pw_r <= PW_LOW;
               end
            end
            PW_LOW:
            begin
               if (pd_s)
               begin
                  pw_r <= PW_ACTIVE;
               end
               else if (low_cnt_r >= PD_LONG)
               begin
                  pw_r <= PW_OFF;
               end
               else
               begin
                  low_cnt_r <= low_cnt_r + PD_CNT_W'(1);
               end
            end
            PW_OFF:
            begin
               if (pd_s)
               begin
                  pw_r <= PW_ACTIVE;
               end
            end
            default:
            begin
               pw_r <= PW_ACTIVE;
            end
         endcase
      end
   end

   assign pulse_rst = (pw_r == PW_LOW) && pd_s && (low_cnt_r >= PD_MIN);

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         full_pd_r <= 1'b0;
      end
      else
      begin
         full_pd_r <= (pw_r == PW_OFF) && !pd_s;
      end
   end

   // One reset for power-on, pulse and full power-down; it also clears the link side
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N || full_pd_r || pulse_rst)
      begin
         link_rst_r <= 1'b1;
         hold_r <= '0;
      end
      else if (hold_r != HOLD_LAST)
      begin
         hold_r <= hold_r + 2'h1;
      end
      else
      begin
         link_rst_r <= 1'b0;
      end
   end

   assign core_rst = !I_RST_N || link_rst_r;

   always_ff @(posedge I_CLK)
   begin
      if (core_rst)
      begin
         wake_cnt_r <= '0;
         ready_r <= 1'b0;
      end
      else if (wake_cnt_r == WAKE_LAST)
      begin
         ready_r <= 1'b1;
      end
      else
      begin
         wake_cnt_r <= wake_cnt_r + TIMER_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // System domain: temperature integration, conversion and averaging
   logic [15:0] ctrl_r;
   logic tstart_tgl_r;
   logic tdone_tgl_r;
   apt_ts_e ts_r;
   logic [TIMER_W-1:0] tcnt_r;
   logic [CODE_W-1:0] temp_res_r;
   logic avg_valid_r;
   logic busy_r;
   logic avg_clr;

   apt_sync u_pdb_sync (.i_clk(I_CLK), .i_rst_n(!core_rst), .i_d(ctrl_r[CTRL_PWR_DN_BIT]),
      .o_q(pdb_s));
   apt_sync u_avg_sync (.i_clk(I_CLK), .i_rst_n(!core_rst),
      .i_d(ctrl_r[CTRL_TEMP_AVG_BIT]), .o_q(avg_s));
   apt_sync u_tsel_sync (.i_clk(I_CLK), .i_rst_n(!core_rst),
      .i_d(ctrl_r[CTRL_TEMP_SEL_BIT]), .o_q(tsel_s));
   apt_sync u_tst_sync (.i_clk(I_CLK), .i_rst_n(!core_rst), .i_d(tstart_tgl_r),
      .o_q(tstart_s));

   always_ff @(posedge I_CLK)
   begin
      if (core_rst)
      begin
         pdb_q_r <= 1'b0;
         avg_q_r <= 1'b0;
         tstart_q_r <= 1'b0;
      end
      else
      begin
         pdb_q_r <= pdb_s;
         avg_q_r <= avg_s;
         tstart_q_r <= tstart_s;
      end
   end

   // Average restarts on a change of the enable or on entering partial power-down
   assign avg_clr = (avg_s ^ avg_q_r) || (pdb_s && !pdb_q_r);

   always_ff @(posedge I_CLK)
   begin
      if (core_rst)
      begin
         ts_r <= TS_IDLE;
         tcnt_r <= '0;
         busy_r <= 1'b0;
         tdone_tgl_r <= 1'b0;
      end
      else
      begin
         case (ts_r)
            TS_IDLE:
            begin
               tcnt_r <= '0;
               if (tstart_s ^ tstart_q_r)
               begin
                  ts_r <= TS_INTEG;
                  busy_r <= 1'b1;
               end
            end
            TS_INTEG:
            begin
               if (tcnt_r == INTEG_LAST)
               begin
                  tcnt_r <= '0;
                  ts_r <= TS_CONV;
               end
               else
               begin
                  tcnt_r <= tcnt_r + TIMER_W'(1);
               end
            end
            TS_CONV:
            begin
               if (tcnt_r == CONV_LAST)
               begin
                  ts_r <= TS_IDLE;
                  busy_r <= 1'b0;
                  tdone_tgl_r <= !tdone_tgl_r;
               end
               else
               begin
                  tcnt_r <= tcnt_r + TIMER_W'(1);
               end
            end
            default:
            begin
               ts_r <= TS_IDLE;
            end
         endcase
      end
   end

   // Result is a signed quarter-degree code; a capture in a restart cycle wins
   always_ff @(posedge I_CLK)
   begin
      if (core_rst)
      begin
         temp_res_r <= '0;
         avg_valid_r <= 1'b0;
      end
      else if ((ts_r == TS_CONV) && (tcnt_r == CONV_LAST))
      begin
         if (avg_s && tsel_s && avg_valid_r && !avg_clr)
         begin
            temp_res_r <= avg_step(temp_res_r, I_TEMP_CODE);
         end
         else
         begin
            temp_res_r <= I_TEMP_CODE;
         end
         avg_valid_r <= 1'b1;
      end
      else if (avg_clr)
      begin
         avg_valid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Link domain: serial frame, control word, sequencer, read word
   logic [4:0] cnt_r;
   logic [14:0] rx_r;
   logic [15:0] tx_r;
   logic [NUM_CH:0] pend_r;
   logic [ID_W-1:0] conv_ch_r;
   logic conv_valid_r;
   logic partial_r;
   logic dout_r;
   logic oe_r;
   logic tdone_m_r;
   logic tdone_s_r;
   logic tdone_q_r;
   logic [CODE_W-1:0] temp_link_r;
   logic [15:0] wr_word;
   logic [NUM_CH:0] avail;
   logic [ID_W-1:0] pick;
   logic [15:0] rd_word;

   assign wr_word = {rx_r, I_DIN};
   assign avail = ((pend_r == '0) && ctrl_r[CTRL_REPEAT_BIT]) ? seq_mask(ctrl_r) : pend_r;
   assign pick = lowest(avail);
   assign rd_word = {conv_ch_r, (conv_ch_r == TEMP_ID) ? temp_link_r : I_CH_CODE};

   // Chip select high clears the bit count at once, so a short frame is dropped
   always_ff @(negedge I_SCLK or posedge link_rst_r or posedge I_CS_N)
   begin
      if (link_rst_r || I_CS_N)
      begin
         cnt_r <= '0;
         oe_r <= 1'b0;
      end
      else if (cnt_r != FRAME_DONE)
      begin
         cnt_r <= cnt_r + 5'h01;
         oe_r <= (cnt_r != LAST_EDGE);
      end
   end

   always_ff @(negedge I_SCLK or posedge link_rst_r)
   begin
      if (link_rst_r)
      begin
         tdone_m_r <= 1'b0;
         tdone_s_r <= 1'b0;
         tdone_q_r <= 1'b0;
         temp_link_r <= '0;
      end
      else
      begin
         tdone_m_r <= tdone_tgl_r;
         tdone_s_r <= tdone_m_r;
         tdone_q_r <= tdone_s_r;
         if (tdone_s_r ^ tdone_q_r)
         begin
            temp_link_r <= temp_res_r;
         end
      end
   end

   always_ff @(negedge I_SCLK or posedge link_rst_r)
   begin
      if (link_rst_r)
      begin
         ctrl_r <= CTRL_RST_VAL;
         rx_r <= '0;
         tx_r <= TX_RST_VAL;
         pend_r <= '0;
         conv_ch_r <= '0;
         conv_valid_r <= 1'b0;
         partial_r <= 1'b0;
         dout_r <= 1'b0;
         tstart_tgl_r <= 1'b0;
      end
      else if (!I_CS_N && (cnt_r != FRAME_DONE))
      begin
         rx_r <= wr_word[14:0];
         if (cnt_r == '0)
         begin
            conv_valid_r <= (avail != '0);
            conv_ch_r <= pick;
            pend_r <= avail & ~((NUM_CH + 1)'(avail != '0) << pick);
            if ((avail != '0) && (pick == TEMP_ID))
            begin
               tstart_tgl_r <= !tstart_tgl_r;
            end
         end
         if (cnt_r == LAST_EDGE)
         begin
            if (conv_valid_r)
            begin
               tx_r <= rd_word;
            end
            else
            begin
               tx_r <= {tx_r[14:0], tx_r[15]};
            end
            if (wr_word[CTRL_WRITE_BIT])
            begin
               ctrl_r <= wr_word;
               pend_r <= seq_mask(wr_word);
               partial_r <= wr_word[CTRL_PWR_DN_BIT];
            end
            if (wr_word[CTRL_WRITE_BIT] ? wr_word[CTRL_PWR_DN_BIT] : partial_r)
            begin
               dout_r <= 1'b1;
            end
            else
            begin
               dout_r <= conv_valid_r ? rd_word[15] : tx_r[14];
            end
         end
         else
         begin
            // Rotate, so a frame without a new result reads the old word again
            tx_r <= {tx_r[14:0], tx_r[15]};
            dout_r <= partial_r ? 1'b1 : tx_r[14];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(negedge I_SCLK or posedge link_rst_r)
   begin
      if (link_rst_r)
      begin
         O_MUX_SEL <= '0;
      end
      else if (!I_CS_N && (cnt_r == '0))
      begin
         O_MUX_SEL <= pick;
      end
   end

   assign O_DOUT = dout_r;
   assign O_DOUT_OE = oe_r;
   assign O_EXT_REF = ctrl_r[CTRL_EXT_REF_BIT];
   assign O_PARTIAL_PD = partial_r;
   assign O_FULL_PD = full_pd_r;
   assign O_READY = ready_r;
   assign O_TEMP_BUSY = busy_r;
endmodule : apt_ctrl

// >>> apt_ctrl_props.sv
/*
 Concurrent checks on the ports of the converter control block.
 Assumes the 100 MHz system clock and the synchronous active-low reset of the block.
*/
`timescale 1ns/1ns
module apt_ctrl_props
   import apt_pkg::*;
#(
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter int TEMP_CYCLES = TEMP_TOTAL_CYC
)
(
   input wire logic I_CLK,                    // System clock
   input wire logic I_RST_N,                  // Reset, active low
   input wire logic I_PD_N,                   // Power-down pin
   input wire logic I_SCLK,                   // Serial clock
   input wire logic I_CS_N,                   // Chip select
   input wire logic I_DIN,                    // Serial write data
   input wire logic [CODE_W-1:0] I_CH_CODE,   // Channel code
   input wire logic [CODE_W-1:0] I_TEMP_CODE, // Temperature code
   input wire logic O_DOUT,                   // Serial read data
   input wire logic O_DOUT_OE,                // Read data enable
   input wire logic [ID_W-1:0] O_MUX_SEL,     // Channel under conversion
   input wire logic O_EXT_REF,                // External reference
   input wire logic O_PARTIAL_PD,             // Partial power-down
   input wire logic O_FULL_PD,                // Full power-down
   input wire logic O_READY,                  // Wake delay elapsed
   input wire logic O_TEMP_BUSY               // Temperature pending
);
   logic [3:0] lo_cnt_r;
   logic [15:0] rdy_cnt_r;
   logic [15:0] busy_cnt_r;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);
   ////////////////////////////////////////////////////////////////////////////////////////
   // Pin low time, wake wait and busy length counters
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N || I_PD_N)
         lo_cnt_r <= 4'h0;
      else if (lo_cnt_r != 4'hf)
         lo_cnt_r <= lo_cnt_r + 4'h1;
   end
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N || !I_PD_N || O_FULL_PD || O_READY)
         rdy_cnt_r <= 16'h0000;
      else if (rdy_cnt_r != 16'hffff)
         rdy_cnt_r <= rdy_cnt_r + 16'h0001;
   end
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N || !O_TEMP_BUSY)
         busy_cnt_r <= 16'h0000;
      else if (busy_cnt_r != 16'hffff)
         busy_cnt_r <= busy_cnt_r + 16'h0001;
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   // Assertions
   AST_FULL_PD_ON: assert property (lo_cnt_r == 4'hf |-> O_FULL_PD)
      else $error("full power-down not entered");
   AST_SHORT_PULSE: assert property (I_PD_N && lo_cnt_r inside {[4'h1:4'h6]} |-> !O_FULL_PD [*5])
      else $error("short pulse powered down");
   // The internal reset reaches the system-side outputs two cycles after entry
   AST_PD_CLEARS: assert property (O_FULL_PD && $past(O_FULL_PD) && $past(O_FULL_PD, 2)
      |-> O_MUX_SEL == 4'h0
      && !(O_READY || O_TEMP_BUSY || O_EXT_REF || O_PARTIAL_PD || O_DOUT_OE))
      else $error("state kept in full power-down");
   AST_PD_EXIT: assert property ($rose(I_PD_N) && O_FULL_PD |-> ##[1:5] !O_FULL_PD)
      else $error("full power-down not left");
   AST_WAKE_DELAY: assert property ($rose(O_READY) |-> rdy_cnt_r inside {[WAKE_CYCLES:WAKE_CYCLES+8]})
      else $error("ready at wrong time");
   AST_BUSY_LEN: assert property ($fell(O_TEMP_BUSY) && I_PD_N && $past(I_PD_N, 4) |-> busy_cnt_r == TEMP_CYCLES)
      else $error("busy length wrong");
   AST_BUSY_START: assert property ($rose(O_TEMP_BUSY) |-> !$past(I_CS_N, 4))
      else $error("busy rose outside a frame");
   AST_OE_IDLE: assert property (I_CS_N && $past(I_CS_N) |-> !O_DOUT_OE)
      else $error("read data driven while deselected");
   AST_PPD_ONES: assert property (O_PARTIAL_PD && !I_CS_N && O_DOUT_OE |-> O_DOUT)
      else $error("partial power-down data not ones");
   AST_MUX_IN_FRAME: assert property ($changed(O_MUX_SEL) && O_MUX_SEL != 4'h0 |-> !I_CS_N)
      else $error("channel changed outside a frame");
   COV_FULL_PD: cover property ($rose(O_FULL_PD));
   COV_TEMP: cover property ($fell(O_TEMP_BUSY));
   COV_PPD: cover property ($rose(O_PARTIAL_PD));
endmodule : apt_ctrl_props

bind apt_ctrl apt_ctrl_props #(.WAKE_CYCLES(WAKE_CYCLES), .TEMP_CYCLES(TEMP_CYCLES)) u_apt_ctrl_props
(
   .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PD_N(I_PD_N), .I_SCLK(I_SCLK), .I_CS_N(I_CS_N),
   .I_DIN(I_DIN), .I_CH_CODE(I_CH_CODE), .I_TEMP_CODE(I_TEMP_CODE), .O_DOUT(O_DOUT),
   .O_DOUT_OE(O_DOUT_OE), .O_MUX_SEL(O_MUX_SEL), .O_EXT_REF(O_EXT_REF),
   .O_PARTIAL_PD(O_PARTIAL_PD), .O_FULL_PD(O_FULL_PD), .O_READY(O_READY),
   .O_TEMP_BUSY(O_TEMP_BUSY)
);

// >>> apt_host_model.sv
/*
 Host serial controller: runs framed transfers, 16 falls MSB first, 160 ns clock.
 Assumes the block takes write data and shifts read data on falling serial clock edges.
*/
`timescale 1ns/1ns
module apt_host_model
(
   input wire logic i_dout, // Serial read data
   output logic o_sclk,     // Serial clock, idle high
   output logic o_cs_n,     // Chip select
   output logic o_din       // Serial write data
);
   initial
   begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_din = 1'b0;
   end
   // Clock stands still outside frames; n below 16 aborts the frame
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      #37;
      o_cs_n = 1'b0;
      for (int k = 0; k < n; k++)
      begin
         o_din = w[15-k];
         #80;
         r[15-k] = i_dout;
         o_sclk = 1'b0;
         #80;
         o_sclk = 1'b1;
      end
      #80;
      o_cs_n = 1'b1;
      o_din = ~o_din;
   endtask : xfer
endmodule : apt_host_model

// >>> tb.sv
/*
 Self-checking bench: power-on, pin reset, full power-down, sequencing, temperature.
 Assumes short wake and temperature counts set by parameter.
*/
`timescale 1ns/1ns
module tb;
   import apt_pkg::*;
   localparam int WAKE = 50;
   localparam int TEMPC = 40;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pd_n = 1'b1;
   logic [11:0] ch_code = 12'h000;
   logic [11:0] temp_code = 12'hf60;
   logic sclk, cs_n, din, dout, oe, ext, ppd, fpd, rdy, busy;
   logic [3:0] mux;
   logic [15:0] r;
   int failures = 0;
   int checks = 0;
   always #5 clk = ~clk;
   always @(negedge clk) ch_code <= {mux, 8'hc3};
   apt_ctrl #(.WAKE_CYCLES(WAKE), .TEMP_CYCLES(TEMPC)) u_apt_ctrl
   (
      .I_CLK(clk), .I_RST_N(rst_n), .I_PD_N(pd_n), .I_SCLK(sclk), .I_CS_N(cs_n),
      .I_DIN(din), .I_CH_CODE(ch_code), .I_TEMP_CODE(temp_code), .O_DOUT(dout),
      .O_DOUT_OE(oe), .O_MUX_SEL(mux), .O_EXT_REF(ext), .O_PARTIAL_PD(ppd),
      .O_FULL_PD(fpd), .O_READY(rdy), .O_TEMP_BUSY(busy)
   );
   apt_host_model u_apt_host_model
   (
      .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din)
   );
   ////////////////////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic chkb(input logic got, input logic exp, input string m);
      chk({15'h0000, got}, {15'h0000, exp}, m);
   endtask : chkb
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic wrdy();
      for (int k = 0; k < 300 && rdy !== 1'b1; k++)
         @(negedge clk);
      chkb(rdy, 1'b1, "ready");
   endtask : wrdy
   task automatic frame(input logic [15:0] w, input int n);
      u_apt_host_model.xfer(w, n, r);
   endtask : frame
   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////////////
   // Tests
   initial
   begin
      #400000;
      failures++;
      summarize();
   end
   initial
   begin
      cyc(20);
      rst_n = 1'b1;
      cyc(1);
      chk({11'h000, ext, ppd, fpd, busy, oe}, 16'h0000, "reset outputs");
      cyc(WAKE - 5);
      chkb(rdy, 1'b0, "ready early");
      wrdy();
      $display("test reset done");
      frame(16'h9804, 16);
      chk(r, 16'h0000, "default read");
      chkb(ext, 1'b1, "ext ref");
      frame(16'h0000, 16);
      chk({12'h000, mux}, 16'h0001, "first channel");
      frame(16'h0000, 16);
      chk({12'h000, mux}, 16'h0002, "second channel");
      chk(r, 16'h11c3, "first result");
      frame(16'h7fff, 16);
      chk(r, 16'h22c3, "second result");
      chkb(ppd, 1'b0, "no write");
      frame(16'h0000, 16);
      chk(r, 16'h22c3, "sequence ended");
      $display("test sequence done");
      frame(16'h8001, 8);
      chkb(ppd, 1'b0, "aborted write");
      frame(16'h8001, 16);
      chkb(ppd, 1'b1, "partial entered");
      frame(16'h8000, 16);
      chk(r, 16'hffff, "partial ones");
      chkb(ppd, 1'b0, "partial left");
      $display("test partial done");
      frame(16'h8020, 16);
      fork
         frame(16'h0000, 16);
         begin
            for (int k = 0; k < 400 && busy !== 1'b1; k++)
               @(negedge clk);
            chkb(busy, 1'b1, "busy raised");
         end
      join
      chkb(busy, 1'b0, "busy ended");
      frame(16'h0000, 16);
      chk(r, {TEMP_ID, 12'hf60}, "temperature");
      $display("test temperature done");
      frame(16'h8004, 16);
      pd_n = 1'b0;
      cyc(5);
      pd_n = 1'b1;
      cyc(8);
      chkb(ext, 1'b0, "pulse reset");
      chkb(fpd, 1'b0, "pulse no power-down");
      wrdy();
      pd_n = 1'b0;
      cyc(20);
      chkb(fpd, 1'b1, "full power-down");
      chkb(rdy, 1'b0, "not ready");
      pd_n = 1'b1;
      cyc(6);
      chkb(fpd, 1'b0, "resumed");
      wrdy();
      $display("test power-down done");
      summarize();
   end
endmodule : tb
